// >>> rtl/hpsc_pkg.sv
// shared constants and types for the hot-plug slot control register bank
package hpsc_pkg;

    // register layout, bits 15 down to 6 of the slot control word
    localparam int REG_W = 16;
    localparam int RSVD_HI = 15;
    localparam int RSVD_LO = 13;
    localparam int LSC_EN_BIT = 12;
    localparam int LOCK_BIT = 11;
    localparam int PWR_BIT = 10;
    localparam int PI_HI = 9;
    localparam int PI_LO = 8;
    localparam int AI_HI = 7;
    localparam int AI_LO = 6;

    // reset values: notify off, slot power off, both indicators off
    localparam logic RST_LSC_EN = 1'b0;
    localparam logic RST_PWR = 1'b1;
    localparam logic [1:0] RST_LED = 2'h3;

    // slot power encoding as seen by software
    localparam logic SLOT_POWER_OUTPUT_CODE = 1'b0;
    localparam logic PWR_OFF_CODE = 1'b1;

    // indicator encodings
    localparam logic [1:0] LED_RSVD = 2'h0;
    localparam logic [1:0] LED_ON = 2'h1;
    localparam logic [1:0] LED_BLINK = 2'h2;
    localparam logic [1:0] LED_OFF = 2'h3;

    // timing: both the interlock pulse and the turn-off timeout last 100 ms
    localparam int CLK_MHZ = 250;
    localparam int LOCK_PULSE_MS = 100;
    localparam int TURN_OFF_TIMEOUT_MS = 100;
    localparam int LOCK_PULSE_CYC = LOCK_PULSE_MS * 1000 * CLK_MHZ;
    localparam int TURN_OFF_CYC = TURN_OFF_TIMEOUT_MS * 1000 * CLK_MHZ;

    // slot power sequencer states
    typedef enum logic [1:0]
    {
        PS_ON = 2'b00,
        PS_WAIT_ACK = 2'b01,
        PS_OFF = 2'b10
    } hpsc_pwr_state_t;

    // downstream message requests, each valid a one-cycle pulse
    typedef struct packed
    {
        logic turn_off;
        logic pwr_ind_valid;
        logic [1:0] pwr_ind_state;
        logic atn_ind_valid;
        logic [1:0] atn_ind_state;
    } hpsc_msg_t;

endpackage

// >>> rtl/hpsc_timer.sv
// one-shot cycle timer: busy for exactly CYCLES enabled clocks after start
`timescale 1ns/1ps
module hpsc_timer #(
    parameter int CYCLES = 25000000
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic start,
    input wire logic abort,
    output logic busy,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    localparam logic [CW-1:0] ZERO = '0;

    logic [CW-1:0] count_ff;
    logic busy_ff;
    logic done_ff;

    // a start while running is ignored so a pulse is never stretched
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            busy_ff <= 1'b0;
            count_ff <= '0;
            done_ff <= 1'b0;
        end
        else if (ce)
        begin
            done_ff <= 1'b0;
            if (abort)
            begin
                busy_ff <= 1'b0;
                count_ff <= ZERO;
            end
            else if (!busy_ff)
            begin
                busy_ff <= start;
                count_ff <= ZERO;
            end
            else if (count_ff == LAST)
            begin
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
                count_ff <= ZERO;
            end
            else
            begin
                count_ff <= count_ff + 1'b1;
            end
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;
endmodule

// >>> rtl/hpsc_slot_ctrl.sv
// slot control register bits 15..6 with power sequencing, interlock pulse and indicator messages
// Function
// (R1) bits 15 to 13 are reserved and always read as zero
// (R2) link-state change notification is raised only while its enable bit is set
// (R3) the interlock control bit reads zero and a written zero does nothing
// (R4) writing one pulses the interlock pin high 100 ms if interlock present
// (R5) slot power bit reads back power state; write drives power pin, 0 means on
// (R6) on-to-off with message enable sends turn-off, waits ack or 100 ms
// (R7) power indicator field reads back state and drives the power LED pin
// (R8) a write changing the power indicator field sends an indicator message
// (R9) attention indicator field reads back state and drives attention LED pin
// (R10) a write changing attention field sends a message; 00b is reserved
// (R11) attention field encoding matches power field: 01 on, 10 blink, 11 off
`timescale 1ns/1ps
module hpsc_slot_ctrl #(
    parameter int LOCK_CYCLES = hpsc_pkg::LOCK_PULSE_CYC,
    parameter int TURN_OFF_CYCLES = hpsc_pkg::TURN_OFF_CYC
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic cfg_wr,
    input wire logic [hpsc_pkg::REG_W-1:0] cfg_wdata,
    output logic [hpsc_pkg::REG_W-1:0] cfg_rdata,
    input wire logic interlock_present,
    input wire logic hotplug_power_message_enable,
    input wire logic link_state_changed_flag,
    input wire logic pme_to_ack,
    output logic link_state_notify,
    output logic interlock_pulse_pin,
    output logic slot_power_output_pin,
    output logic [1:0] power_led_pin,
    output logic [1:0] attention_led_pin,
    output hpsc_pkg::hpsc_msg_t msg
);
    import hpsc_pkg::*;

    logic link_state_change_notify_enable_ff;
    logic slot_power_control_ff;
    logic [1:0] power_led_control_ff;
    logic [1:0] attention_led_control_ff;
    hpsc_pwr_state_t pwr_state_ff;
    hpsc_pwr_state_t nxt_pwr_state;
    logic [REG_W-1:0] rdata_ff;
    logic notify_ff;
    logic pwr_pin_ff;
    hpsc_msg_t msg_ff;
    logic lock_start;
    logic lock_busy;
    logic to_start;
    logic to_abort;
    logic to_done;
    logic [1:0] wr_pi;
    logic [1:0] wr_ai;
    logic wr_pwr;

    // a reserved indicator code is a legal write that leaves the field alone
    function automatic logic led_code_ok(input logic [1:0] code);
        return code != LED_RSVD;
    endfunction

    assign wr_pi = cfg_wdata[PI_HI:PI_LO];
    assign wr_ai = cfg_wdata[AI_HI:AI_LO];
    assign wr_pwr = cfg_wdata[PWR_BIT];

    // writable control fields
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            link_state_change_notify_enable_ff <= RST_LSC_EN;
            slot_power_control_ff <= RST_PWR;
            power_led_control_ff <= RST_LED;
            attention_led_control_ff <= RST_LED;
        end
        else if (ce && cfg_wr)
        begin
            link_state_change_notify_enable_ff <= cfg_wdata[LSC_EN_BIT];
            // (R5) power state write
            slot_power_control_ff <= wr_pwr;
            // (R7) power indicator update
            if (led_code_ok(wr_pi))
            begin
                power_led_control_ff <= wr_pi;
            end
            // (R9) (R11) attention indicator update
            if (led_code_ok(wr_ai))
            begin
                attention_led_control_ff <= wr_ai;
            end
        end
    end

    // (R3) (R4) only a written one starts the pulse, and only with an interlock fitted
    assign lock_start = ce && cfg_wr && cfg_wdata[LOCK_BIT] && interlock_present;

    hpsc_timer #(
        .CYCLES(LOCK_CYCLES)
    ) u_lock_timer (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .start(lock_start),
        .abort(1'b0),
        .busy(lock_busy),
        .done()
    );

    // power sequencer next state; a power-on write always wins, even mid handshake
    always_comb
    begin
        nxt_pwr_state = pwr_state_ff;
        to_start = 1'b0;
        to_abort = 1'b0;
        unique case (pwr_state_ff)
            PS_ON:
            begin
                // (R6) orderly shutdown only when the message enable is set
                if (cfg_wr && wr_pwr == PWR_OFF_CODE)
                begin
                    if (hotplug_power_message_enable)
                    begin
                        nxt_pwr_state = PS_WAIT_ACK;
                        to_start = 1'b1;
                    end
                    else
                    begin
                        nxt_pwr_state = PS_OFF;
                    end
                end
            end
            PS_WAIT_ACK:
            begin
                if (cfg_wr && wr_pwr == SLOT_POWER_OUTPUT_CODE)
                begin
                    nxt_pwr_state = PS_ON;
                    to_abort = 1'b1;
                end
                // (R6) release power on ack or timeout
                else if (pme_to_ack || to_done)
                begin
                    nxt_pwr_state = PS_OFF;
                    to_abort = 1'b1;
                end
            end
            PS_OFF:
            begin
                if (cfg_wr && wr_pwr == SLOT_POWER_OUTPUT_CODE)
                begin
                    nxt_pwr_state = PS_ON;
                end
            end
            default:
            begin
                nxt_pwr_state = PS_OFF;
            end
        endcase
    end

    hpsc_timer #(
        .CYCLES(TURN_OFF_CYCLES)
    ) u_off_timer (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .start(to_start && ce),
        .abort(to_abort && ce),
        .busy(),
        .done(to_done)
    );

    // sequencer state and the power pin, which stays on through the handshake
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            pwr_state_ff <= PS_OFF;
            pwr_pin_ff <= 1'b0;
        end
        else if (ce)
        begin
            pwr_state_ff <= nxt_pwr_state;
            // (R5) pin high means slot powered
            pwr_pin_ff <= nxt_pwr_state != PS_OFF;
        end
    end

    // downstream messages, one-cycle pulses carrying the new state
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            msg_ff <= '0;
        end
        else if (ce)
        begin
            // (R6) turn-off request
            msg_ff.turn_off <= to_start;
            // (R8) power indicator changed
            msg_ff.pwr_ind_valid <= cfg_wr && led_code_ok(wr_pi) && wr_pi != power_led_control_ff;
            msg_ff.pwr_ind_state <= wr_pi;
            // (R10) attention indicator changed
            msg_ff.atn_ind_valid <= cfg_wr && led_code_ok(wr_ai) && wr_ai != attention_led_control_ff;
            msg_ff.atn_ind_state <= wr_ai;
        end
    end

    // notification is a level that follows the flag while enabled
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            notify_ff <= 1'b0;
        end
        else if (ce)
        begin
            // (R2) gate the notification with its enable
            notify_ff <= link_state_change_notify_enable_ff && link_state_changed_flag;
        end
    end

    // read data lags the fields by one cycle; bits 5..0 belong elsewhere and read zero here
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            rdata_ff <= '0;
        end
        else if (ce)
        begin
            // (R1) (R3) reserved and interlock bits are never set
            rdata_ff <= '0;
            rdata_ff[LSC_EN_BIT] <= link_state_change_notify_enable_ff;
            rdata_ff[PWR_BIT] <= slot_power_control_ff;
            rdata_ff[PI_HI:PI_LO] <= power_led_control_ff;
            rdata_ff[AI_HI:AI_LO] <= attention_led_control_ff;
        end
    end

    assign cfg_rdata = rdata_ff;
    assign link_state_notify = notify_ff;
    assign interlock_pulse_pin = lock_busy;
    assign slot_power_output_pin = pwr_pin_ff;
    assign power_led_pin = power_led_control_ff;
    assign attention_led_pin = attention_led_control_ff;
    assign msg = msg_ff;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    sequence s_off_request;
        ce && cfg_wr && wr_pwr == PWR_OFF_CODE && pwr_state_ff == PS_ON && hotplug_power_message_enable;
    endsequence

    sequence s_held_on;
        slot_power_output_pin && pwr_state_ff == PS_WAIT_ACK;
    endsequence

    a_rsvd_zero: assert property (cfg_rdata[RSVD_HI:RSVD_LO] == 3'h0) // (R1)
        else $error("reserved bits read nonzero");
    a_notify_gate: assert property (ce |=> link_state_notify == $past(link_state_change_notify_enable_ff
        && link_state_changed_flag)) // (R2)
        else $error("notification not gated by enable");
    a_lock_reads_zero: assert property (cfg_rdata[LOCK_BIT] == 1'b0) // (R3)
        else $error("interlock bit read as one");
    a_lock_ignored: assert property (ce && cfg_wr && cfg_wdata[LOCK_BIT] && !interlock_present
        && !interlock_pulse_pin |=> !interlock_pulse_pin) // (R4)
        else $error("interlock pulse without interlock present");
    a_lock_start: assert property (lock_start && !interlock_pulse_pin |=> interlock_pulse_pin) // (R4)
        else $error("interlock pulse not started");
    a_power_readback: assert property (ce && cfg_wr |=> slot_power_control_ff == $past(wr_pwr)) // (R5)
        else $error("power bit did not take written value");
    a_turnoff_handshake: assert property (s_off_request |=> msg.turn_off ##0 s_held_on) // (R6)
        else $error("turn-off message or power hold missing");
    a_direct_off: assert property (ce && cfg_wr && wr_pwr == PWR_OFF_CODE && pwr_state_ff == PS_ON
        && !hotplug_power_message_enable |=> !slot_power_output_pin) // (R6)
        else $error("power not removed without message enable");
    a_ack_release: assert property (ce && pwr_state_ff == PS_WAIT_ACK && pme_to_ack && !cfg_wr
        |=> !slot_power_output_pin) // (R6)
        else $error("power held after ack");
    a_pi_msg: assert property (ce && cfg_wr && wr_pi != LED_RSVD && wr_pi != power_led_control_ff
        |=> msg.pwr_ind_valid && power_led_pin == msg.pwr_ind_state) // (R7) (R8)
        else $error("power indicator message missing");
    a_ai_msg: assert property (ce && cfg_wr && wr_ai != attention_led_control_ff
        |=> msg.atn_ind_valid == ($past(wr_ai) != LED_RSVD)) // (R9) (R10)
        else $error("attention indicator message wrong");
endmodule

// >>> tb/hpsc_partner.sv
// far-side model: answers the turn-off message with an acknowledge after a set delay
`timescale 1ns/1ps
module hpsc_partner (
    input wire logic clock,
    input wire logic turn_off,
    input wire logic [7:0] ack_delay,
    output logic pme_to_ack
);
    int cnt = 0;
    initial pme_to_ack = 1'b0;
    // acknowledge after delay
    // a zero delay never answers, so the design must fall back on its timeout
    always @(posedge clock)
    begin
        pme_to_ack <= 1'b0;
        if (turn_off === 1'b1 && ack_delay != 8'h00)
            cnt <= ack_delay;
        else if (cnt > 0)
        begin
            cnt <= cnt - 1;
            pme_to_ack <= (cnt == 1);
        end
    end
endmodule

// >>> tb/hpsc_slot_ctrl_test.sv
// self-checking bench for the slot control register bank
`timescale 1ns/1ps
module hpsc_slot_ctrl_test;
    import hpsc_pkg::*;
    localparam int LCYC = 20;
    localparam int TCYC = 20;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic cfg_wr = 1'b0;
    logic [15:0] cfg_wdata = 16'h0000;
    logic [15:0] cfg_rdata;
    logic present = 1'b0;
    logic msg_en = 1'b0;
    logic flag = 1'b0;
    logic ack, notify, lock_pin, pwr_pin;
    logic [1:0] pled, aled;
    hpsc_msg_t msg;
    logic [7:0] ack_delay = 8'h00;
    logic [3:0] notes[$];
    logic [1:0] pi_exp = 2'h3;
    logic [1:0] ai_exp = 2'h3;
    logic pwr_exp = 1'b1;
    logic lsc_exp = 1'b0;
    logic [31:0] seed = 32'h14ad50df;
    int mismatches = 0;
    int samples_checked = 0;
    int cyc = 0;
    int lock_hi = 0;
    int n;

    hpsc_slot_ctrl #(.LOCK_CYCLES(LCYC), .TURN_OFF_CYCLES(TCYC)) hpsc_slot_ctrl_i (.clock(clock), .nrst(nrst),
        .ce(ce), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .interlock_present(present),
        .hotplug_power_message_enable(msg_en), .link_state_changed_flag(flag), .pme_to_ack(ack),
        .link_state_notify(notify), .interlock_pulse_pin(lock_pin), .slot_power_output_pin(pwr_pin),
        .power_led_pin(pled), .attention_led_pin(aled), .msg(msg));
    hpsc_partner hpsc_partner_i (.clock(clock), .turn_off(msg.turn_off), .ack_delay(ack_delay), .pme_to_ack(ack));

    initial
    begin
        forever #2 clock = ~clock;
    end

    task automatic end_sim;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // notes expected messages, drives one write; reserved bits written as ones to prove they are dropped
    task automatic wr(input logic [1:0] pi, input logic [1:0] ai, input logic pwr, input logic lock);
        if (pi != 2'h0 && pi != pi_exp) notes.push_back({2'h0, pi});
        if (ai != 2'h0 && ai != ai_exp) notes.push_back({2'h1, ai});
        if (pwr && !pwr_exp && msg_en) notes.push_back(4'h8);
        if (pi != 2'h0) pi_exp = pi;
        if (ai != 2'h0) ai_exp = ai;
        pwr_exp = pwr;
        @(negedge clock);
        cfg_wr = 1'b1;
        cfg_wdata = {3'h7, lsc_exp, lock, pwr, pi, ai, 6'h3f};
        @(negedge clock);
        cfg_wr = 1'b0;
        chk("power_led_pin", {14'h0, pi_exp}, {14'h0, pled});
        chk("attention_led_pin", {14'h0, ai_exp}, {14'h0, aled});
        @(negedge clock);
        chk("cfg_rdata", {3'h0, lsc_exp, 1'b0, pwr_exp, pi_exp, ai_exp, 6'h00}, cfg_rdata);
    endtask

    task automatic take(input logic [3:0] seen);
        logic [3:0] nt;
        nt = 4'hf;
        if (notes.size() > 0) nt = notes.pop_front();
        chk("msg", {12'h0, nt}, {12'h0, seen});
    endtask

    // each message pulse retires the oldest note; pulses last one cycle, so sample every edge
    always @(posedge clock)
    begin
        if (nrst === 1'b1)
        begin
            if (msg.pwr_ind_valid === 1'b1) take({2'h0, msg.pwr_ind_state});
            if (msg.atn_ind_valid === 1'b1) take({2'h1, msg.atn_ind_state});
            if (msg.turn_off === 1'b1) take(4'h8);
        end
        if (lock_pin === 1'b1) lock_hi++;
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            end_sim();
        end
    end

    initial
    begin
        repeat (3) @(negedge clock);
        nrst = 1'b1;
        repeat (2) @(negedge clock);
        chk("reset cfg_rdata", 16'h07c0, cfg_rdata);
        chk("reset power pin", 16'h0, {15'h0, pwr_pin});
        for (int i = 0; i < 20; i++)
        begin
            seed = xs(seed);
            if (i < 4) wr(i[1:0], 2'(3 - i), 1'b1, 1'b0);
            else wr(seed[1:0], seed[3:2], 1'b1, 1'b0);
        end
        flag = 1'b1;
        repeat (2) @(negedge clock);
        chk("notify disabled", 16'h0, {15'h0, notify});
        lsc_exp = 1'b1;
        wr(pi_exp, ai_exp, 1'b1, 1'b0);
        chk("notify enabled", 16'h1, {15'h0, notify});
        flag = 1'b0;
        repeat (2) @(negedge clock);
        chk("notify follows flag", 16'h0, {15'h0, notify});
        lock_hi = 0;
        wr(pi_exp, ai_exp, 1'b1, 1'b1);
        chk("lock absent", 16'h0, lock_hi[15:0]);
        present = 1'b1;
        wr(pi_exp, ai_exp, 1'b1, 1'b1);
        repeat (2 * LCYC) @(negedge clock);
        chk("lock width", 16'(LCYC), lock_hi[15:0]);
        wr(pi_exp, ai_exp, 1'b0, 1'b0);
        chk("power on pin", 16'h1, {15'h0, pwr_pin});
        wr(pi_exp, ai_exp, 1'b1, 1'b0);
        chk("power off pin", 16'h0, {15'h0, pwr_pin});
        // clock enable low: a write is ignored and the bank holds
        ce = 1'b0;
        @(negedge clock);
        cfg_wr = 1'b1;
        cfg_wdata = {3'h0, lsc_exp, 1'b0, ~pwr_exp, ~pi_exp, ~ai_exp, 6'h00};
        @(negedge clock);
        cfg_wr = 1'b0;
        @(negedge clock);
        ce = 1'b1;
        @(negedge clock);
        chk("frozen cfg_rdata", {3'h0, lsc_exp, 1'b0, pwr_exp, pi_exp, ai_exp, 6'h00}, cfg_rdata);
        chk("frozen power pin", 16'h0, {15'h0, pwr_pin});
        // acknowledge then timeout end the wait
        msg_en = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            ack_delay = (k == 0) ? 8'h05 : 8'h00;
            wr(pi_exp, ai_exp, 1'b0, 1'b0);
            wr(pi_exp, ai_exp, 1'b1, 1'b0);
            chk("power held in wait", 16'h1, {15'h0, pwr_pin});
            n = 2;
            while (pwr_pin === 1'b1 && n < 40)
            begin
                @(negedge clock);
                n++;
            end
            if (k == 0) chk("ack drop", 16'h1, {15'h0, n < TCYC});
            else chk("timeout drop", 16'h1, {15'h0, n >= TCYC && n <= TCYC + 3});
        end
        repeat (4) @(negedge clock);
        // power on, then a mid-run reset with the clock enable low, which must still reset
        wr(pi_exp, ai_exp, 1'b0, 1'b0);
        ce = 1'b0;
        nrst = 1'b0;
        repeat (3) @(negedge clock);
        nrst = 1'b1;
        ce = 1'b1;
        pi_exp = 2'h3;
        ai_exp = 2'h3;
        pwr_exp = 1'b1;
        lsc_exp = 1'b0;
        repeat (2) @(negedge clock);
        chk("second reset cfg_rdata", 16'h07c0, cfg_rdata);
        chk("second reset power pin", 16'h0, {15'h0, pwr_pin});
        chk("notes left", 16'h0, 16'(notes.size()));
        end_sim();
    end
endmodule
